// ==== common/uart_aux_defs.svh ====
/*
  Register indices, field positions and reset values of the auxiliary
  control and status register bank.
  Assumes inclusion by bare name from every file that decodes registers.
*/
`ifndef UART_AUX_DEFS_SVH
`define UART_AUX_DEFS_SVH

// ----------------------------------------------------------------------
// Register word indices (Avalon word address)
// ----------------------------------------------------------------------
`define IDX_MODE_A        4'h0
`define IDX_CMD_A         4'h1
`define IDX_AUX_CONTROL   4'h2
`define IDX_INPUT_CHANGE  4'h3
`define IDX_INT_STATUS    4'h4
`define IDX_INT_MASK      4'h5
`define IDX_TIMER_UPPER   4'h6
`define IDX_TIMER_LOWER   4'h7
`define IDX_INT_VECTOR    4'h8
`define IDX_OUT_CONFIG    4'h9
`define IDX_OUT_SET       4'ha
`define IDX_OUT_CLEAR     4'hb
`define IDX_OUT_VALUE     4'hc

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define AUX_BRG_BIT       7
`define AUX_TMODE_MSB     6
`define AUX_TMODE_LSB     4
`define AUX_IPEN_MSB      3
`define MODE_RXRTS_BIT    7
`define MODE_RXINT_BIT    6
`define CMD_MSB           6
`define CMD_LSB           4
`define CMD_SET_PTR       3'h1
`define CFG_OP4_BIT       4
`define CFG_OP5_BIT       5
`define CFG_OP6_BIT       6
`define CFG_OP7_BIT       7
`define BYTE_MSB          7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define REG_RESET         8'h00
`define IVR_RESET         8'h00
`define IP_RESET          4'hf
`define PIN_RESET         8'hff
`define DELTA_RESET       4'h0
`define RDATA_RESET       32'h00000000
`define RD_PAD            24'h000000

`endif

// ==== common/uart_aux_pkg.sv ====
/*
  Types shared by the auxiliary register bank.
  Assumes the rest of the channel logic supplies status in these forms.
*/
package uart_aux_pkg;

  // Status a channel reports to the interrupt logic
  typedef struct packed {
    logic break_change;
    logic rx_ready;
    logic fifo_full;
    logic tx_ready;
  } chan_stat_t;

  // Mode register pointer of channel A
  typedef enum logic {
    PTR_FIRST,
    PTR_SECOND
  } mode_ptr_t;

endpackage

// ==== hdl/in_change_detect.sv ====
/*
  Synchronises four input pins and keeps sticky change flags.
  Assumes the clear mask is a one-cycle pulse from the register read.
*/
`timescale 1ns/10ps
`include "uart_aux_defs.svh"
module in_change_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins
  input wire logic [3:0] pin_in,
  // Flag control
  input wire logic [3:0] clear_mask,
  // Results
  output logic [3:0] level,
  output logic [3:0] delta
);

  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] prev_r;
  logic [3:0] delta_r;

  // Two-stage synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= `IP_RESET;
      sync2_r <= `IP_RESET;
      prev_r <= `IP_RESET;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Sticky change flags, a new change beats the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delta_r <= `DELTA_RESET;
    end else begin
      delta_r <= (delta_r & ~clear_mask) | (sync2_r ^ prev_r);
    end
  end

  assign level = prev_r;
  assign delta = delta_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_flag_sticky;
    (delta_r[0] && !clear_mask[0]) |=> delta_r[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("change flag lost without clear");

  property p_flag_set;
    (sync2_r[1] != prev_r[1]) |=> delta_r[1] ##0 level[1] == $past(sync2_r[1]);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("input change not flagged");

endmodule

// ==== hdl/uart_aux_regs.sv ====
/*
  Auxiliary control and status register bank of a dual serial channel
  controller, reached over an Avalon-MM slave with waitrequest.
  Assumes channel status and start-bit pulses come from logic on clk;
  the input pins are asynchronous.
*/
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "uart_aux_defs.svh"
module uart_aux_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Channel status
  input uart_aux_pkg::chan_stat_t chan_a_stat,
  input uart_aux_pkg::chan_stat_t chan_b_stat,
  input wire logic chan_b_rx_cond,
  input wire logic counter_ready,
  input wire logic chan_a_start_bit,
  // Pins
  input wire logic [3:0] in_pin,
  output logic [7:0] out_pin,
  output logic irq,
  // Settings for the rest of the device
  output logic baud_set_sel,
  output logic [2:0] timer_mode,
  output logic [15:0] timer_preset,
  output logic [7:0] chan_a_mode_first,
  output logic [7:0] chan_a_mode_second,
  output logic [7:0] interrupt_vector
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic [7:0] aux_control_r;
  logic [7:0] interrupt_mask_r;
  logic [7:0] interrupt_status_r;
  logic [7:0] interrupt_status_nxt;
  logic [7:0] timer_upper_r;
  logic [7:0] timer_lower_r;
  logic [7:0] interrupt_vector_r;
  logic [7:0] output_pin_config_r;
  logic [7:0] output_port_value_r;
  logic [7:0] mode_first_r;
  logic [7:0] mode_second_r;
  logic [7:0] out_pin_r;
  logic [7:0] out_pin_nxt;
  logic [3:0] delta_seen_r;
  logic [3:0] delta_clear;
  logic [3:0] in_level;
  logic [3:0] in_delta;
  logic [7:0] wdata;
  logic irq_r;
  logic rts_hold_r;
  logic rx_cond_a;
  logic accept;
  uart_aux_pkg::mode_ptr_t ptr_r;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [3:0] addr,
                               input logic [3:0] idx,
                               input logic strobe);
    hit = strobe && (addr == idx);
  endfunction

  // Read data for a register index
  function automatic logic [7:0] rd_mux(input logic [3:0] idx);
    rd_mux = `REG_RESET;
    unique case (idx)
      `IDX_MODE_A: begin
        rd_mux = (ptr_r == uart_aux_pkg::PTR_FIRST) ? mode_first_r
                                                     : mode_second_r;
      end
      `IDX_INPUT_CHANGE: rd_mux = {in_delta, in_level};
      `IDX_INT_STATUS: rd_mux = interrupt_status_r;
      `IDX_INT_VECTOR: rd_mux = interrupt_vector_r;
      `IDX_OUT_VALUE: rd_mux = output_port_value_r;
      default: rd_mux = `REG_RESET;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Avalon slave handshake
  // ----------------------------------------------------------------------
  assign accept = (read || write) && !waitrequest_r;
  assign wdata = writedata[`BYTE_MSB:0];

  // One wait cycle, then answer for one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest_r <= 1'b1;
    end else if ((read || write) && waitrequest_r) begin
      waitrequest_r <= 1'b0;
    end else begin
      waitrequest_r <= 1'b1;
    end
  end

  // Read data captured during the wait cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_r <= `RDATA_RESET;
      delta_seen_r <= `DELTA_RESET;
    end else if (read && waitrequest_r) begin
      readdata_r <= {`RD_PAD, rd_mux(address)};
      delta_seen_r <= in_delta;
    end
  end

  // Only flags that were reported get cleared
  assign delta_clear = hit(address, `IDX_INPUT_CHANGE, read && accept)
                       ? delta_seen_r : 4'h0;

  // ----------------------------------------------------------------------
  // Plain control registers
  // ----------------------------------------------------------------------
  // Aux control, mask, timer preset, vector, pin config
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_control_r <= `REG_RESET;
      interrupt_mask_r <= `REG_RESET;
      timer_upper_r <= `REG_RESET;
      timer_lower_r <= `REG_RESET;
      interrupt_vector_r <= `IVR_RESET;
      output_pin_config_r <= `REG_RESET;
    end else begin
      if (hit(address, `IDX_AUX_CONTROL, write && accept)) begin
        aux_control_r <= wdata;
      end
      if (hit(address, `IDX_INT_MASK, write && accept)) begin
        interrupt_mask_r <= wdata;
      end
      if (hit(address, `IDX_TIMER_UPPER, write && accept)) begin
        timer_upper_r <= wdata;
      end
      if (hit(address, `IDX_TIMER_LOWER, write && accept)) begin
        timer_lower_r <= wdata;
      end
      if (hit(address, `IDX_INT_VECTOR, write && accept)) begin
        interrupt_vector_r <= wdata;
      end
      if (hit(address, `IDX_OUT_CONFIG, write && accept)) begin
        output_pin_config_r <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel A mode registers and pointer
  // ----------------------------------------------------------------------
  // Pointer: set-pointer command, advance on first-register access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_r <= uart_aux_pkg::PTR_FIRST;
    end else if (hit(address, `IDX_CMD_A, write && accept) &&
                 wdata[`CMD_MSB:`CMD_LSB] == `CMD_SET_PTR) begin
      ptr_r <= uart_aux_pkg::PTR_FIRST;
    end else if (hit(address, `IDX_MODE_A, accept) &&
                 ptr_r == uart_aux_pkg::PTR_FIRST) begin
      ptr_r <= uart_aux_pkg::PTR_SECOND;
    end
  end

  // Mode register storage through the pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_first_r <= `REG_RESET;
      mode_second_r <= `REG_RESET;
    end else if (hit(address, `IDX_MODE_A, write && accept)) begin
      if (ptr_r == uart_aux_pkg::PTR_FIRST) begin
        mode_first_r <= wdata;
      end else begin
        mode_second_r <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output port value
  // ----------------------------------------------------------------------
  // Bit set and bit clear commands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_port_value_r <= `REG_RESET;
    end else if (hit(address, `IDX_OUT_SET, write && accept)) begin
      output_port_value_r <= output_port_value_r | wdata;
    end else if (hit(address, `IDX_OUT_CLEAR, write && accept)) begin
      output_port_value_r <= output_port_value_r & ~wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Receiver flow control
  // ----------------------------------------------------------------------
  // Hold request-to-send off while the FIFO stays full
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rts_hold_r <= 1'b0;
    end else if (!chan_a_stat.fifo_full ||
                 !mode_first_r[`MODE_RXRTS_BIT]) begin
      rts_hold_r <= 1'b0;
    end else if (chan_a_start_bit) begin
      rts_hold_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and request
  // ----------------------------------------------------------------------
  // Receive condition chosen by mode bit 6
  assign rx_cond_a = mode_first_r[`MODE_RXINT_BIT]
                     ? chan_a_stat.fifo_full : chan_a_stat.rx_ready;

  // Status bits, input change first
  always_comb begin
    interrupt_status_nxt = {
      |(in_delta & aux_control_r[`AUX_IPEN_MSB:0]),
      chan_b_stat.break_change,
      chan_b_rx_cond,
      chan_b_stat.tx_ready,
      counter_ready,
      chan_a_stat.break_change,
      rx_cond_a,
      chan_a_stat.tx_ready
    };
  end

  // Status register and masked request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_status_r <= `REG_RESET;
      irq_r <= 1'b0;
    end else begin
      interrupt_status_r <= interrupt_status_nxt;
      irq_r <= |(interrupt_status_nxt & interrupt_mask_r);
    end
  end

  // ----------------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------------
  // Pin levels are inverted register or status bits
  always_comb begin
    out_pin_nxt = ~output_port_value_r;
    out_pin_nxt[0] = ~(output_port_value_r[0] & ~rts_hold_r);
    if (output_pin_config_r[`CFG_OP4_BIT]) begin
      out_pin_nxt[4] = ~rx_cond_a;
    end
    if (output_pin_config_r[`CFG_OP5_BIT]) begin
      out_pin_nxt[5] = ~chan_b_rx_cond;
    end
    if (output_pin_config_r[`CFG_OP6_BIT]) begin
      out_pin_nxt[6] = ~chan_a_stat.tx_ready;
    end
    if (output_pin_config_r[`CFG_OP7_BIT]) begin
      out_pin_nxt[7] = ~chan_b_stat.tx_ready;
    end
  end

  // Registered pin drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_pin_r <= `PIN_RESET;
    end else begin
      out_pin_r <= out_pin_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Input change detection
  // ----------------------------------------------------------------------
  in_change_detect u_in_change (
    .clk(clk),
    .rst(rst),
    .pin_in(in_pin),
    .clear_mask(delta_clear),
    .level(in_level),
    .delta(in_delta)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign out_pin = out_pin_r;
  assign irq = irq_r;
  assign baud_set_sel = aux_control_r[`AUX_BRG_BIT];
  assign timer_mode = aux_control_r[`AUX_TMODE_MSB:`AUX_TMODE_LSB];
  assign timer_preset = {timer_upper_r, timer_lower_r};
  assign chan_a_mode_first = mode_first_r;
  assign chan_a_mode_second = mode_second_r;
  assign interrupt_vector = interrupt_vector_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_set_bits;
    hit(address, `IDX_OUT_SET, write && accept) |=>
      output_port_value_r == ($past(output_port_value_r) | $past(wdata));
  endproperty
  a_set_bits: assert property (p_set_bits)
    else $error("set command wrong");

  property p_clear_bits;
    hit(address, `IDX_OUT_CLEAR, write && accept) |=>
      output_port_value_r == ($past(output_port_value_r) & ~$past(wdata));
  endproperty
  a_clear_bits: assert property (p_clear_bits)
    else $error("clear command wrong");

  property p_ptr_reset;
    (hit(address, `IDX_CMD_A, write && accept) &&
     wdata[`CMD_MSB:`CMD_LSB] == `CMD_SET_PTR) |=>
      ptr_r == uart_aux_pkg::PTR_FIRST;
  endproperty
  a_ptr_reset: assert property (p_ptr_reset)
    else $error("set pointer ignored");

  property p_ptr_advance;
    (hit(address, `IDX_MODE_A, accept) && ptr_r == uart_aux_pkg::PTR_FIRST)
      |=> ptr_r == uart_aux_pkg::PTR_SECOND;
  endproperty
  a_ptr_advance: assert property (p_ptr_advance)
    else $error("pointer did not advance");

  property p_rts_follow;
    !rts_hold_r |=> out_pin[0] == !$past(output_port_value_r[0]);
  endproperty
  a_rts_follow: assert property (p_rts_follow)
    else $error("request-to-send not following bit zero");

  property p_rts_negate;
    (mode_first_r[`MODE_RXRTS_BIT] && chan_a_stat.fifo_full &&
     chan_a_start_bit) |-> ##2 out_pin[0];
  endproperty
  a_rts_negate: assert property (p_rts_negate)
    else $error("request-to-send not negated on full FIFO");

  property p_rts_release;
    (rts_hold_r && !chan_a_stat.fifo_full) |=> !rts_hold_r;
  endproperty
  a_rts_release: assert property (p_rts_release)
    else $error("request-to-send not restored");

  property p_rx_select;
    ##1 interrupt_status_r[1] == ($past(mode_first_r[`MODE_RXINT_BIT])
      ? $past(chan_a_stat.fifo_full) : $past(chan_a_stat.rx_ready));
  endproperty
  a_rx_select: assert property (p_rx_select)
    else $error("receive interrupt source wrong");

  property p_op4_src;
    output_pin_config_r[`CFG_OP4_BIT] |=> out_pin[4] == !$past(rx_cond_a);
  endproperty
  a_op4_src: assert property (p_op4_src)
    else $error("pin four source wrong");

  property p_pin_invert;
    ##1 out_pin[1] == !$past(output_port_value_r[1]);
  endproperty
  a_pin_invert: assert property (p_pin_invert)
    else $error("pin one not inverted");

  property p_irq;
    irq == |(interrupt_status_r & $past(interrupt_mask_r));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request mismatch");

  property p_answer;
    ((read || write) && waitrequest) |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer late");

  c_rts_hold: cover property ($rose(rts_hold_r) ##[1:20] $fell(rts_hold_r));
  c_ptr: cover property ($changed(ptr_r));
  c_irq: cover property ($rose(irq));
  c_input_change_status: cover property (delta_clear != 4'h0);

endmodule

// ==== tb/test_uart_aux_regs.sv ====
/*
  Self-checking bench of the auxiliary register bank.
  Assumes the host model file and the shared header and package.
*/
`timescale 1ns/10ps
`include "uart_aux_defs.svh"
module test_uart_aux_regs;
  logic clk, rst, read, write, waitrequest, irq, send, start_bit;
  logic chan_b_rx_cond, counter_ready, baud_set_sel;
  logic [3:0] address, in_pin, np;
  logic [31:0] writedata, readdata, v;
  logic [7:0] out_pin, chan_a_mode_first, chan_a_mode_second;
  logic [7:0] interrupt_vector, q, output_port_value, m, e;
  logic [2:0] timer_mode;
  logic [15:0] timer_preset;
  uart_aux_pkg::chan_stat_t chan_a_stat, chan_b_stat;
  integer seed;
  int bad_count, tests_run;

  // ----------------------------------------------------------------
  // Instances and clock
  // ----------------------------------------------------------------
  uart_aux_regs uart_aux_regs_inst (.clk(clk), .rst(rst),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .chan_a_stat(chan_a_stat),
    .chan_b_stat(chan_b_stat), .chan_b_rx_cond(chan_b_rx_cond),
    .counter_ready(counter_ready), .chan_a_start_bit(start_bit),
    .in_pin(in_pin), .out_pin(out_pin), .irq(irq),
    .baud_set_sel(baud_set_sel), .timer_mode(timer_mode),
    .timer_preset(timer_preset), .chan_a_mode_first(chan_a_mode_first),
    .chan_a_mode_second(chan_a_mode_second),
    .interrupt_vector(interrupt_vector));
  uart_host_model uart_host_model_inst (.clk(clk), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .send(send),
    .rts_n(out_pin[0]), .start_bit(start_bit));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] x;
    uart_host_model_inst.access(a, 1'b1, d, x);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    uart_host_model_inst.access(a, 1'b0, 8'h00, x);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Expected status byte from the driven conditions
  function automatic logic [7:0] isr_exp(logic ipc, logic sel);
    logic rxa;
    rxa = sel ? chan_a_stat.fifo_full : chan_a_stat.rx_ready;
    return {ipc, chan_b_stat.break_change, chan_b_rx_cond,
      chan_b_stat.tx_ready, counter_ready, chan_a_stat.break_change,
      rxa, chan_a_stat.tx_ready};
  endfunction
  // Counts, verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hc00c5595;
    rst = 1'b1;
    send = 1'b0;
    in_pin = 4'hf;
    chan_a_stat = 4'h0;
    chan_b_stat = 4'h0;
    chan_b_rx_cond = 1'b0;
    counter_ready = 1'b0;
    cyc(6);
    rst <= 1'b0;
    cyc(1);
    chk(out_pin, 8'hff);
    rd(`IDX_INT_VECTOR, q);
    chk(q, 8'h00);
    rd(4'hd, q);
    chk(q, 8'h00);
    rd(`IDX_AUX_CONTROL, q);
    chk(q, 8'h00);
    $display("test reset done");
    // Plain registers with random data
    repeat (4) begin
      v = $random(seed);
      wr(`IDX_INT_VECTOR, v[7:0]);
      rd(`IDX_INT_VECTOR, q);
      chk(q, v[7:0]);
      wr(`IDX_AUX_CONTROL, v[15:8]);
      wr(`IDX_TIMER_UPPER, v[23:16]);
      wr(`IDX_TIMER_LOWER, v[31:24]);
      cyc(1);
      chk(baud_set_sel, v[15]);
      chk(timer_preset, {v[23:16], v[31:24]});
      chk(timer_mode, v[14:12]);
      chk(interrupt_vector, v[7:0]);
    end
    $display("test registers done");
    // Output bit set and clear commands
    output_port_value = 8'h00;
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      m = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : v[7:0];
      wr(`IDX_OUT_SET, m);
      output_port_value = output_port_value | m;
      cyc(2);
      chk(out_pin, 8'(~output_port_value));
      m = (i == 1) ? 8'hff : (i == 0) ? 8'h00 : v[15:8];
      wr(`IDX_OUT_CLEAR, m);
      output_port_value = output_port_value & ~m;
      cyc(2);
      chk(out_pin, 8'(~output_port_value));
      rd(`IDX_OUT_VALUE, q);
      chk(q, output_port_value);
    end
    $display("test output port done");
    // Mode register pointer
    v = $random(seed);
    wr(`IDX_CMD_A, 8'h10);
    wr(`IDX_MODE_A, {1'b0, v[6:0]});
    wr(`IDX_MODE_A, v[15:8]);
    cyc(1);
    chk(chan_a_mode_first, {1'b0, v[6:0]});
    chk(chan_a_mode_second, v[15:8]);
    wr(`IDX_CMD_A, 8'h10);
    rd(`IDX_MODE_A, q);
    chk(q, {1'b0, v[6:0]});
    rd(`IDX_MODE_A, q);
    chk(q, v[15:8]);
    $display("test mode pointer done");
    // Status order, masking and pin four source
    wr(`IDX_OUT_CONFIG, 8'hf0);
    for (int s = 0; s < 2; s++) begin
      wr(`IDX_CMD_A, 8'h10);
      wr(`IDX_MODE_A, {1'b0, s[0], 6'h00});
      for (int i = 0; i < 8; i++) begin
        v = $random(seed);
        @(posedge clk);
        {chan_a_stat, chan_b_stat} <= v[7:0];
        chan_b_rx_cond <= v[8];
        counter_ready <= v[9];
        m = (i == 0) ? 8'h00 : v[23:16];
        wr(`IDX_INT_MASK, m);
        cyc(2);
        e = isr_exp(1'b0, s[0]);
        rd(`IDX_INT_STATUS, q);
        chk(q, e);
        chk(irq, |(e & m));
        chk(out_pin[7:4], 4'(~{e[4], e[0], e[5], e[1]}));
      end
    end
    wr(`IDX_OUT_CONFIG, 8'h00);
    cyc(2);
    chk(out_pin[7:4], 4'(~output_port_value[7:4]));
    $display("test status done");
    // Input change flags
    @(posedge clk);
    chan_a_stat <= 4'h0;
    chan_b_stat <= 4'h0;
    wr(`IDX_AUX_CONTROL, 8'h0f);
    wr(`IDX_INT_MASK, 8'h80);
    v = $random(seed);
    np = (v[3:0] == 4'hf) ? 4'h5 : v[3:0];
    @(posedge clk);
    in_pin <= np;
    cyc(8);
    chk(irq, 1'b1);
    rd(`IDX_INT_STATUS, q);
    chk(q[7], 1'b1);
    rd(`IDX_INPUT_CHANGE, q);
    chk(q, {np ^ 4'hf, np});
    rd(`IDX_INPUT_CHANGE, q);
    chk(q, {4'h0, np});
    cyc(3);
    chk(irq, 1'b0);
    wr(`IDX_AUX_CONTROL, 8'h00);
    @(posedge clk);
    in_pin <= ~np;
    cyc(8);
    chk(irq, 1'b0);
    rd(`IDX_INPUT_CHANGE, q);
    chk(q, {4'hf, ~np});
    $display("test input change done");
    // Receiver flow control
    wr(`IDX_CMD_A, 8'h10);
    wr(`IDX_MODE_A, 8'h80);
    wr(`IDX_OUT_SET, 8'h01);
    @(posedge clk);
    chan_a_stat <= 4'b0010;
    cyc(2);
    chk(out_pin[0], 1'b0);
    @(posedge clk);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    cyc(4);
    chk(out_pin[0], 1'b1);
    rd(`IDX_OUT_VALUE, q);
    chk(q[0], 1'b1);
    @(posedge clk);
    chan_a_stat <= 4'b0000;
    cyc(4);
    chk(out_pin[0], 1'b0);
    $display("test flow control done");
    results;
  end

  // Watchdog against a hung handshake
  initial begin
    #500000;
    bad_count++;
    results;
  end
endmodule

// ==== tb/uart_host_model.sv ====
/*
  Host bus master and a remote sender of start bits.
  Assumes an Avalon-MM slave with waitrequest on the same clock.
*/
`timescale 1ns/10ps
module uart_host_model (
  // Clock
  input wire logic clk,
  // Avalon-MM master
  output logic [3:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Remote sender
  input wire logic send,
  input wire logic rts_n,
  output logic start_bit
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle bus at time zero
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
  end

  // One transfer, held until waitrequest is sampled low
  task automatic access(input logic [3:0] a, input logic wr,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= {24'h000000, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a; // Released lines do not keep old value
    writedata <= ~{24'h000000, d};
  endtask

  // Remote sender holds off while request-to-send is negated
  always @(posedge clk) begin
    start_bit <= send & ~rts_n;
  end
endmodule
